// ===== radio_status_pkg.sv
// Constants, field layouts and reset values of the receive status register bank.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
// Function
// - The CRC check of the latest received packet reads as one bit, 0 for failure, 1 for pass.
// - The logical address index of the previous packet is held until the next reception.
// - The CRC field of the previous packet is captured for software to read after reception.
// - A read-only index tells which configured device address matched the received packet.
// - Tone extension info of a received packet reads as time, reserved and type fields.
package radio_status_pkg;
	localparam int          ADDR_W              = 12;
	localparam int          DATA_W              = 32;
	localparam int          STRB_W              = DATA_W / 8;
	localparam int          IRQ_N               = 3;

	localparam logic [11:0] OFF_CRC_RESULT      = 12'h400;
	localparam logic [11:0] OFF_MATCHED_LADDR   = 12'h408;
	localparam logic [11:0] OFF_CAPTURED_CRC    = 12'h40c;
	localparam logic [11:0] OFF_DEV_ADDR_INDEX  = 12'h410;
	localparam logic [11:0] OFF_PAYLOAD_STATUS  = 12'h414;
	localparam logic [11:0] OFF_TONE_EXT_INFO   = 12'h44c;
	localparam logic [11:0] OFF_DF_STATE        = 12'h458;
	localparam logic [11:0] OFF_PACKET_PTR      = 12'h504;
	localparam logic [11:0] OFF_IRQ_STATUS      = 12'h600;
	localparam logic [11:0] OFF_IRQ_MASK        = 12'h604;

	localparam logic        CRC_FAILED_VALUE    = 1'h0;
	localparam logic        CRC_PASSED_VALUE    = 1'h1;

	localparam int          LADDR_W             = 3;
	localparam int          RX_CRC_W            = 24;
	localparam int          DAI_W               = 3;
	localparam int          PDU_EXCEEDS_BIT     = 0;
	localparam int          PDU_CI_LSB          = 1;
	localparam int          PDU_CI_W            = 2;
	localparam int          TONE_TIME_LSB       = 0;
	localparam int          TONE_TIME_W         = 5;
	localparam int          TONE_RSVD_BIT       = 5;
	localparam int          TONE_TYPE_LSB       = 6;
	localparam int          TONE_TYPE_W         = 2;
	localparam int          TONE_INFO_W         = 8;
	localparam int          SWITCH_STATE_LSB    = 0;
	localparam int          SWITCH_STATE_W      = 3;
	localparam int          SAMPLER_STATE_BIT   = 4;

	localparam int          IRQ_RX_END_BIT      = 0;
	localparam int          IRQ_CRC_ERR_BIT     = 1;
	localparam int          IRQ_TONE_BIT        = 2;

	localparam logic [31:0] RESET_WORD          = 32'h00000000;
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_SLVERR         = 2'h2;
endpackage

// ===== reg_access_if.sv
// Register access strobes between the bus slave port and the register bank.
// Assumes one clock domain; strobes are single-cycle.
`timescale 1ns/10ps
interface reg_access_if
	import radio_status_pkg::*;
	();
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [STRB_W-1:0] wr_strb;
	logic              wr_ok;
	logic              rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              rd_ok;

	modport port (
		output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input  wr_ok, rd_data, rd_ok
	);
	modport bank (
		input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_ok, rd_data, rd_ok
	);
endinterface

// ===== axil_slave_port.sv
// AXI4-Lite slave front end turning bus transfers into register strobes.
// Assumes the bank answers read data and decode status combinationally.
`timescale 1ns/10ps
module axil_slave_port
	import radio_status_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] awaddr_i,
	input  wire logic              awvalid_i,
	output logic                   awready_o,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic [STRB_W-1:0] wstrb_i,
	input  wire logic              wvalid_i,
	output logic                   wready_o,
	output logic [1:0]             bresp_o,
	output logic                   bvalid_o,
	input  wire logic              bready_i,
	input  wire logic [ADDR_W-1:0] araddr_i,
	input  wire logic              arvalid_i,
	output logic                   arready_o,
	output logic [DATA_W-1:0]      rdata_o,
	output logic [1:0]             rresp_o,
	output logic                   rvalid_o,
	input  wire logic              rready_i,
	reg_access_if.port             ra
);
	logic              aw_full_q;
	logic              w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [STRB_W-1:0] w_strb_q;
	wire               aw_take = ce_i & awvalid_i & ~aw_full_q;
	wire               w_take  = ce_i & wvalid_i & ~w_full_q;
	wire               ar_take = ce_i & arvalid_i & ~rvalid_o;
	wire               wr_fire = ce_i & aw_full_q & w_full_q & ~bvalid_o;

	assign ra.wr_en   = wr_fire;
	assign ra.wr_addr = aw_addr_q;
	assign ra.wr_data = w_data_q;
	assign ra.wr_strb = w_strb_q;
	assign ra.rd_en   = ar_take;
	assign ra.rd_addr = araddr_i;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_o <= 1'b1;
			wready_o  <= 1'b1;
			arready_o <= 1'b1;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_o  <= 1'b0;
			bresp_o   <= RESP_OKAY;
			rvalid_o  <= 1'b0;
			rdata_o   <= '0;
			rresp_o   <= RESP_OKAY;
		end else if (ce_i) begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awready_o <= 1'b0;
				aw_addr_q <= awaddr_i;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wready_o <= 1'b0;
				w_data_q <= wdata_i;
				w_strb_q <= wstrb_i;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				awready_o <= 1'b1;
				wready_o  <= 1'b1;
				bvalid_o  <= 1'b1;
				bresp_o   <= ra.wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
			if (ar_take) begin
				rvalid_o  <= 1'b1;
				arready_o <= 1'b0;
				rdata_o   <= ra.rd_data;
				rresp_o   <= ra.rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rready_i) begin
				rvalid_o  <= 1'b0;
				arready_o <= 1'b1;
			end
		end
	end
endmodule

// ===== irq_status_unit.sv
// Sticky event flags, write-one-to-clear, with a mask onto one level interrupt.
// Assumes events are one-cycle pulses in the system clock domain.
`timescale 1ns/10ps
module irq_status_unit #(
	parameter int N = 3
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_n_i,
	input  wire logic         ce_i,
	input  wire logic [N-1:0] event_i,
	input  wire logic [N-1:0] clear_i,
	input  wire logic         mask_we_i,
	input  wire logic [N-1:0] mask_d_i,
	output logic [N-1:0]      status_o,
	output logic [N-1:0]      mask_o,
	output logic              irq_o
);
	// Set wins over a clear in the same cycle
	wire [N-1:0] status_d = (status_o & ~clear_i) | event_i;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			status_o <= '0;
			mask_o   <= '0;
			irq_o    <= 1'b0;
		end else if (ce_i) begin
			status_o <= status_d;
			if (mask_we_i) begin
				mask_o <= mask_d_i;
			end
			irq_o <= |(status_d & (mask_we_i ? mask_d_i : mask_o));
		end
	end
endmodule

// ===== radio_rx_status_regs.sv
// Receive result registers, packet pointer and event interrupt of the radio.
// Assumes receive results are valid in the cycle rx_end_i pulses, and DF states are live levels.
`timescale 1ns/10ps
module radio_rx_status_regs
	import radio_status_pkg::*;
#(
	parameter int PTR_W = 32
) (
	input  wire logic                      clk_sys_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      ce_i,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [DATA_W-1:0]         s_axi_wdata,
	input  wire logic [STRB_W-1:0]         s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [DATA_W-1:0]              s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Receive datapath results
	input  wire logic                      rx_end_i,
	input  wire logic                      rx_crc_ok_i,
	input  wire logic [LADDR_W-1:0]        rx_logical_addr_i,
	input  wire logic [RX_CRC_W-1:0]       rx_crc_field_i,
	input  wire logic [DAI_W-1:0]          rx_dev_addr_index_i,
	input  wire logic                      rx_pdu_exceeds_i,
	input  wire logic [PDU_CI_W-1:0]       rx_pdu_ci_i,
	input  wire logic                      tone_present_i,
	input  wire logic [TONE_INFO_W-1:0]    tone_info_i,
	input  wire logic [SWITCH_STATE_W-1:0] antenna_switch_fsm_state_i,
	input  wire logic                      sampler_fsm_state_i,
	// Packet buffer start strobes
	input  wire logic                      tx_start_i,
	input  wire logic                      rx_start_i,
	output logic [PTR_W-1:0]               packet_addr_o,
	output logic                           packet_is_tx_o,
	output logic                           irq_o
);
	reg_access_if ra ();

	logic                      s_awready;
	logic                      s_wready;
	logic                      s_arready;
	logic [1:0]                s_bresp;
	logic                      s_bvalid;
	logic [DATA_W-1:0]         s_rdata;
	logic [1:0]                s_rresp;
	logic                      s_rvalid;

	logic                      crc_result_q;
	logic [LADDR_W-1:0]        matched_laddr_q;
	logic [RX_CRC_W-1:0]       captured_crc_q;
	logic [DAI_W-1:0]          dev_addr_index_q;
	logic                      pdu_exceeds_q;
	logic [PDU_CI_W-1:0]       pdu_ci_q;
	logic [TONE_INFO_W-1:0]    tone_info_q;
	logic [SWITCH_STATE_W-1:0] switch_state_q;
	logic                      sampler_state_q;
	logic [PTR_W-1:0]          packet_ptr_q;
	logic [PTR_W-1:0]          packet_ptr_d;
	logic [IRQ_N-1:0]          irq_status;
	logic [IRQ_N-1:0]          irq_mask;
	logic [IRQ_N-1:0]          irq_events;
	logic [DATA_W-1:0]         rd_mux;

	axil_slave_port u_port (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.awaddr_i  (s_axi_awaddr),
		.awvalid_i (s_axi_awvalid),
		.awready_o (s_awready),
		.wdata_i   (s_axi_wdata),
		.wstrb_i   (s_axi_wstrb),
		.wvalid_i  (s_axi_wvalid),
		.wready_o  (s_wready),
		.bresp_o   (s_bresp),
		.bvalid_o  (s_bvalid),
		.bready_i  (s_axi_bready),
		.araddr_i  (s_axi_araddr),
		.arvalid_i (s_axi_arvalid),
		.arready_o (s_arready),
		.rdata_o   (s_rdata),
		.rresp_o   (s_rresp),
		.rvalid_o  (s_rvalid),
		.rready_i  (s_axi_rready),
		.ra        (ra.port)
	);

	// AXI outputs are flip-flops inside the port
	assign s_axi_awready = s_awready;
	assign s_axi_wready  = s_wready;
	assign s_axi_arready = s_arready;
	assign s_axi_bresp   = s_bresp;
	assign s_axi_bvalid  = s_bvalid;
	assign s_axi_rdata   = s_rdata;
	assign s_axi_rresp   = s_rresp;
	assign s_axi_rvalid  = s_rvalid;

	// Word-aligned address decode
	wire [ADDR_W-1:0] wa          = {ra.wr_addr[ADDR_W-1:2], 2'b00};
	wire [ADDR_W-1:0] rda         = {ra.rd_addr[ADDR_W-1:2], 2'b00};
	wire              wr_ptr_sel  = (wa == OFF_PACKET_PTR);
	wire              wr_stat_sel = (wa == OFF_IRQ_STATUS);
	wire              wr_mask_sel = (wa == OFF_IRQ_MASK);
	wire              wr_ro_sel   = (wa == OFF_CRC_RESULT) || (wa == OFF_MATCHED_LADDR)
	                             || (wa == OFF_CAPTURED_CRC) || (wa == OFF_DEV_ADDR_INDEX)
	                             || (wa == OFF_PAYLOAD_STATUS) || (wa == OFF_TONE_EXT_INFO)
	                             || (wa == OFF_DF_STATE);
	wire              ptr_we      = ra.wr_en & wr_ptr_sel;
	wire              stat_we     = ra.wr_en & wr_stat_sel & ra.wr_strb[0];
	wire              mask_we     = ra.wr_en & wr_mask_sel & ra.wr_strb[0];

	assign ra.wr_ok = wr_ptr_sel | wr_stat_sel | wr_mask_sel | wr_ro_sel;

	// Byte-lane merge of the pointer write
	genvar gi;
	generate
		for (gi = 0; gi < PTR_W / 8; gi++) begin : g_ptr_lane
			assign packet_ptr_d[gi*8 +: 8] = ra.wr_strb[gi] ? ra.wr_data[gi*8 +: 8]
			                                                : packet_ptr_q[gi*8 +: 8];
		end
	endgenerate

	// Read data selection
	always_comb begin
		rd_mux   = RESET_WORD;
		ra.rd_ok = 1'b1;
		unique case (rda)
			OFF_CRC_RESULT: begin
				rd_mux[0] = crc_result_q;
			end
			OFF_MATCHED_LADDR: begin
				rd_mux[LADDR_W-1:0] = matched_laddr_q;
			end
			OFF_CAPTURED_CRC: begin
				rd_mux[RX_CRC_W-1:0] = captured_crc_q;
			end
			OFF_DEV_ADDR_INDEX: begin
				rd_mux[DAI_W-1:0] = dev_addr_index_q;
			end
			OFF_PAYLOAD_STATUS: begin
				rd_mux[PDU_EXCEEDS_BIT]                 = pdu_exceeds_q;
				rd_mux[PDU_CI_LSB +: PDU_CI_W]          = pdu_ci_q;
			end
			OFF_TONE_EXT_INFO: begin
				rd_mux[TONE_TIME_LSB +: TONE_TIME_W] = tone_info_q[TONE_TIME_LSB +: TONE_TIME_W];
				rd_mux[TONE_RSVD_BIT]                = tone_info_q[TONE_RSVD_BIT];
				rd_mux[TONE_TYPE_LSB +: TONE_TYPE_W] = tone_info_q[TONE_TYPE_LSB +: TONE_TYPE_W];
			end
			OFF_DF_STATE: begin
				rd_mux[SWITCH_STATE_LSB +: SWITCH_STATE_W] = switch_state_q;
				rd_mux[SAMPLER_STATE_BIT]                  = sampler_state_q;
			end
			OFF_PACKET_PTR: begin
				rd_mux[PTR_W-1:0] = packet_ptr_q;
			end
			OFF_IRQ_STATUS: begin
				rd_mux[IRQ_N-1:0] = irq_status;
			end
			OFF_IRQ_MASK: begin
				rd_mux[IRQ_N-1:0] = irq_mask;
			end
			default: begin
				ra.rd_ok = 1'b0;
			end
		endcase
	end

	assign ra.rd_data = rd_mux;

	// Receive result capture at end of packet
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			crc_result_q     <= CRC_FAILED_VALUE;
			matched_laddr_q  <= '0;
			captured_crc_q   <= '0;
			dev_addr_index_q <= '0;
			pdu_exceeds_q    <= 1'b0;
			pdu_ci_q         <= '0;
			tone_info_q      <= '0;
		end else if (ce_i && rx_end_i) begin
			crc_result_q     <= rx_crc_ok_i ? CRC_PASSED_VALUE : CRC_FAILED_VALUE;
			matched_laddr_q  <= rx_logical_addr_i;
			captured_crc_q   <= rx_crc_field_i;
			dev_addr_index_q <= rx_dev_addr_index_i;
			pdu_exceeds_q    <= rx_pdu_exceeds_i;
			pdu_ci_q         <= rx_pdu_ci_i;
			if (tone_present_i) begin
				tone_info_q <= tone_info_i;
			end
		end
	end

	// Live direction finding machine states
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			switch_state_q  <= '0;
			sampler_state_q <= 1'b0;
		end else if (ce_i) begin
			switch_state_q  <= antenna_switch_fsm_state_i;
			sampler_state_q <= sampler_fsm_state_i;
		end
	end

	// Packet pointer register and its hand-off to the buffer mover
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			packet_ptr_q   <= '0;
			packet_addr_o  <= '0;
			packet_is_tx_o <= 1'b0;
		end else if (ce_i) begin
			if (ptr_we) begin
				packet_ptr_q <= packet_ptr_d;
			end
			if (tx_start_i) begin
				packet_addr_o  <= packet_ptr_q;
				packet_is_tx_o <= 1'b1;
			end else if (rx_start_i) begin
				packet_addr_o  <= packet_ptr_q;
				packet_is_tx_o <= 1'b0;
			end
		end
	end

	assign irq_events[IRQ_RX_END_BIT]  = rx_end_i;
	assign irq_events[IRQ_CRC_ERR_BIT] = rx_end_i & ~rx_crc_ok_i;
	assign irq_events[IRQ_TONE_BIT]    = rx_end_i & tone_present_i;

	irq_status_unit #(
		.N (IRQ_N)
	) u_irq (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.event_i   (irq_events),
		.clear_i   (stat_we ? ra.wr_data[IRQ_N-1:0] : {IRQ_N{1'b0}}),
		.mask_we_i (mask_we),
		.mask_d_i  (ra.wr_data[IRQ_N-1:0]),
		.status_o  (irq_status),
		.mask_o    (irq_mask),
		.irq_o     (irq_o)
	);
endmodule

// ===== radio_rx_status_regs_assertions.sv
// Concurrent checks on the ports of the receive status register bank.
// Assumes one clock domain, synchronous active-low reset, bound from the bench.
`timescale 1ns/10ps
module radio_rx_status_regs_assertions
	import radio_status_pkg::*;
#(
	parameter int PTR_W = 32
) (
	input wire logic              clk_sys_i,
	input wire logic              reset_n_i,
	input wire logic              ce_i,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              rx_end_i,
	input wire logic              tx_start_i,
	input wire logic              rx_start_i,
	input wire logic [PTR_W-1:0]  packet_addr_o,
	input wire logic              packet_is_tx_o,
	input wire logic              irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i || !ce_i);

	AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address taken but awready stays high");
	AST_W_HELD: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data taken but wready stays high");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stays after handshake");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stays after handshake");
	AST_AR_BLOCK: assert property (s_axi_arready != s_axi_rvalid)
		else $error("arready not the inverse of rvalid");
	AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read returns nonzero data");
	AST_TX_START: assert property (tx_start_i |=> packet_is_tx_o)
		else $error("transmit start not flagged");
	AST_RX_START: assert property (rx_start_i && !tx_start_i |=> !packet_is_tx_o)
		else $error("receive start flagged as transmit");
	AST_PTR_HOLD: assert property (!tx_start_i && !rx_start_i |=> $stable(packet_addr_o))
		else $error("packet address changed without start");
	AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(rx_end_i) || s_axi_bvalid)
		else $error("interrupt rose without event or write");
endmodule

// ===== radio_rx_status_regs_tb.sv
// Self-checking bench of the receive status register bank over AXI4-Lite.
// Assumes the checker module is compiled alongside; clock 25 MHz.
`timescale 1ns/10ps
module radio_rx_status_regs_tb
	import radio_status_pkg::*;
;
	logic                      clk_sys_i, reset_n_i, ce_i, rx_end_i, rx_crc_ok_i;
	logic [ADDR_W-1:0]         s_axi_awaddr, s_axi_araddr;
	logic [2:0]                s_axi_awprot, s_axi_arprot;
	logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                      s_axi_rvalid, s_axi_rready, rx_pdu_exceeds_i, tone_present_i;
	logic [DATA_W-1:0]         s_axi_wdata, s_axi_rdata;
	logic [STRB_W-1:0]         s_axi_wstrb;
	logic [1:0]                s_axi_bresp, s_axi_rresp, rx_pdu_ci_i;
	logic [LADDR_W-1:0]        rx_logical_addr_i;
	logic [RX_CRC_W-1:0]       rx_crc_field_i;
	logic [DAI_W-1:0]          rx_dev_addr_index_i;
	logic [TONE_INFO_W-1:0]    tone_info_i;
	logic [SWITCH_STATE_W-1:0] antenna_switch_fsm_state_i;
	logic                      sampler_fsm_state_i, tx_start_i, rx_start_i, packet_is_tx_o, irq_o;
	logic [31:0]               packet_addr_o;
	int                        mismatches, tests_run;

	radio_rx_status_regs dut (.*);

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
		input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk({29'h0, (n == 50), s_axi_bresp}, {30'h0, er}, "write resp");
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk({29'h0, (n == 50), s_axi_rresp}, {30'h0, er}, "read resp");
		chk(s_axi_rdata, exp, "read data");
	endtask

	task automatic rx_pkt(input logic ok, input logic [2:0] la, input logic [23:0] crc,
		input logic tp, input logic [7:0] ti);
		@(posedge clk_sys_i);
		rx_crc_ok_i <= ok;
		rx_logical_addr_i <= la;
		rx_crc_field_i <= crc;
		tone_present_i <= tp;
		tone_info_i <= ti;
		rx_end_i <= 1'b1;
		@(posedge clk_sys_i);
		rx_end_i <= 1'b0;
	endtask

	task automatic start(input logic t, input logic r, input logic [31:0] exp);
		@(posedge clk_sys_i);
		tx_start_i <= t;
		rx_start_i <= r;
		@(posedge clk_sys_i);
		tx_start_i <= 1'b0;
		rx_start_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(packet_addr_o, exp, "packet address");
		chk({31'h0, packet_is_tx_o}, {31'h0, t}, "packet direction");
	endtask

	task automatic t_reset;
		rchk(OFF_CRC_RESULT, RESET_WORD);
		rchk(OFF_MATCHED_LADDR, RESET_WORD);
		rchk(OFF_CAPTURED_CRC, RESET_WORD);
		rchk(OFF_PACKET_PTR, RESET_WORD);
		rchk(12'h7fc, 32'h0, RESP_SLVERR);
		wr(12'h7fc, 32'h0, 4'hf, RESP_SLVERR);
	endtask

	task automatic t_rx;
		rx_dev_addr_index_i <= 3'h6;
		rx_pdu_exceeds_i <= 1'b1;
		rx_pdu_ci_i <= 2'h2;
		rx_pkt(CRC_PASSED_VALUE, 3'h5, 24'habcdef, 1'b1, 8'hb7);
		rchk(OFF_CRC_RESULT, 32'h1);
		rchk(OFF_MATCHED_LADDR, 32'h5);
		rchk(OFF_CAPTURED_CRC, 32'h00abcdef);
		rchk(OFF_DEV_ADDR_INDEX, 32'h6);
		rchk(OFF_PAYLOAD_STATUS, 32'h5);
		rchk(OFF_TONE_EXT_INFO, 32'hb7);
		rx_pkt(CRC_FAILED_VALUE, 3'h2, 24'h123456, 1'b0, 8'h41);
		rchk(OFF_CRC_RESULT, 32'h0);
		rchk(OFF_TONE_EXT_INFO, 32'hb7);
		ce_i <= 1'b0;
		rx_pkt(CRC_PASSED_VALUE, 3'h7, 24'h0, 1'b0, 8'h0);
		ce_i <= 1'b1;
		wr(OFF_MATCHED_LADDR, 32'hffffffff);
		rchk(OFF_MATCHED_LADDR, 32'h2);
		rchk(OFF_CAPTURED_CRC, 32'h00123456);
	endtask

	task automatic t_df;
		antenna_switch_fsm_state_i <= 3'h5;
		sampler_fsm_state_i <= 1'b1;
		rchk(OFF_DF_STATE, 32'h15);
		antenna_switch_fsm_state_i <= 3'h2;
		sampler_fsm_state_i <= 1'b0;
		rchk(OFF_DF_STATE, 32'h2);
	endtask

	task automatic t_ptr;
		wr(OFF_PACKET_PTR, 32'h20001234);
		rchk(OFF_PACKET_PTR, 32'h20001234);
		start(1'b0, 1'b1, 32'h20001234);
		wr(OFF_PACKET_PTR, 32'hffffffff, 4'h1);
		start(1'b1, 1'b1, 32'h200012ff);
	endtask

	task automatic t_irq;
		rchk(OFF_IRQ_STATUS, 32'h7);
		chk({31'h0, irq_o}, 32'h0, "irq masked");
		wr(OFF_IRQ_MASK, 32'h2);
		chk({31'h0, irq_o}, 32'h1, "irq unmasked");
		wr(OFF_IRQ_STATUS, 32'h2);
		rchk(OFF_IRQ_STATUS, 32'h5);
		chk({31'h0, irq_o}, 32'h0, "irq cleared");
		rx_pkt(CRC_PASSED_VALUE, 3'h1, 24'h0, 1'b0, 8'h0);
		rchk(OFF_IRQ_MASK, 32'h2);
		chk({31'h0, irq_o}, 32'h0, "irq other bit");
		wr(OFF_IRQ_MASK, 32'h1);
		chk({31'h0, irq_o}, 32'h1, "irq rx end");
		wr(OFF_IRQ_STATUS, 32'h7);
		rchk(OFF_IRQ_STATUS, 32'h0);
		chk({31'h0, irq_o}, 32'h0, "irq all cleared");
		rx_pkt(CRC_FAILED_VALUE, 3'h0, 24'h0, 1'b1, 8'h0);
		@(negedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1, "irq on event");
		rchk(OFF_IRQ_STATUS, 32'h7);
	endtask

	task end_sim;
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		end_sim;
	end

	initial begin
		{reset_n_i, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_wdata, s_axi_wstrb, rx_end_i, rx_crc_ok_i, rx_logical_addr_i} = '0;
		{rx_crc_field_i, rx_dev_addr_index_i, rx_pdu_exceeds_i, rx_pdu_ci_i} = '0;
		{tone_present_i, tone_info_i, antenna_switch_fsm_state_i, sampler_fsm_state_i} = '0;
		{tx_start_i, rx_start_i, mismatches, tests_run} = '0;
		ce_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_rx;
		t_df;
		t_ptr;
		t_irq;
		end_sim;
	end
endmodule

bind radio_rx_status_regs radio_rx_status_regs_assertions #(.PTR_W(PTR_W)) chk_i (.*);
